/* shared/modem_spi_pkg.sv */
package modem_spi_pkg;
  localparam int FRAME_BITS = 24;
  localparam int BUF_DEPTH = 2;
  localparam int CLK_HZ = 20_000_000;
  localparam int SCLK_MAX_HZ = 12_500_000;
  localparam int CLKOUT_DIV = 4;
  localparam logic [1:0] IRQ_MODE_LEVEL = 2'h0;
  localparam logic [1:0] IRQ_MODE_PULSE = 2'h1;
  localparam int IRQ_PULSE_CYCLES = 4;
  localparam logic [1:0] SCHEME_INT_OSC = 2'h0;
  localparam logic [1:0] SCHEME_XTAL = 2'h1;
  localparam logic [1:0] SCHEME_EXT_CMOS = 2'h2;
  localparam logic [1:0] SCHEME_XTAL_OUT = 2'h3;
endpackage

/* hw/frame_buffer.sv */
`timescale 1ns/100ps
module frame_buffer
  import modem_spi_pkg::*;
#(
  parameter int WIDTH = FRAME_BITS,
  parameter int DEPTH = BUF_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg, rd_reg;
  logic [AW:0] count_reg;
  logic push, pop;

  assign in_ready = count_reg != (AW+1)'(DEPTH);
  assign out_valid = count_reg != '0;
  assign out_data = mem_reg[rd_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

/* hw/modem_spi_pin_interface.sv */
// Summary of operation
// R01: While chip select is low, incoming serial data bits are captured into the input shift register.
// R02: While chip select is high, the serial output is released to high impedance and serial input is ignored.
// R03: Serial input is sampled on each falling serial clock edge into a 24-bit shift register.
// R04: Serial output is valid at the falling serial clock edge, where the host samples it.
// R05: The host keeps the serial clock at or below 12.5 MHz.
// R06: A low reset pin level powers down and resets the device; high returns normal operation.
// R07: The interrupt output is edge or level style with either polarity, per control settings.
// R08: The interrupt is asserted only for modem events enabled by the interrupt mask.
// R09: A low crystal enable strap turns the crystal oscillator on; high disables it.
// R10: With the internal oscillator or a crystal as source, the clock output pin may drive that clock.
// R11: The clocking scheme is chosen from the two clock configuration straps.
// R12: A high reference enable strap turns on the internal 1.5-V reference, else external is used.
// R13: A high filter enable strap turns on the internal band-pass filter, else external is used.
// R14: Serial output changes on the rising serial clock edge, stable for the next falling edge.
`timescale 1ns/100ps
module modem_spi_pin_interface
  import modem_spi_pkg::*;
#(
  parameter int WIDTH = FRAME_BITS,
  parameter int EVENTS = 8,
  parameter int DIV = CLKOUT_DIV
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic reset_pin_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  output logic [WIDTH-1:0] rx_word,
  output logic rx_valid,
  input wire logic rx_ready,
  input wire logic [WIDTH-1:0] tx_word,
  input wire logic tx_load,
  input wire logic [EVENTS-1:0] modem_events,
  input wire logic [EVENTS-1:0] irq_mask,
  input wire logic [1:0] irq_mode,
  input wire logic irq_active_high,
  output logic irq,
  input wire logic crystal_osc_enable_n,
  input wire logic clock_scheme_strap_0,
  input wire logic clock_scheme_strap_1,
  input wire logic ref_enable_strap,
  input wire logic bandpass_filter_enable,
  input wire logic clock_out_enable,
  output logic clock_out_pin,
  output logic xtal_osc_on,
  output logic [1:0] clock_scheme,
  output logic internal_ref_on,
  output logic internal_filter_on,
  output logic power_down,
  output logic frame_overrun
);
  // Two-flop synchronisers for every pin input
  logic [5:0] s1_reg, s2_reg;
  logic cs_n_s, sclk_s, sdi_s, rstpin_s, xen_s, cfg0_s;
  logic [2:0] s1b_reg, s2b_reg;
  logic cfg1_s, refen_s, bpf_s;
  logic sclk_prev_reg;
  logic core_rst;

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg <= 6'h3D;
      s2_reg <= 6'h3D;
      s1b_reg <= 3'h0;
      s2b_reg <= 3'h0;
    end else begin
      s1_reg <= {cs_n, sclk, sdi, reset_pin_n, crystal_osc_enable_n, clock_scheme_strap_0};
      s2_reg <= s1_reg;
      s1b_reg <= {clock_scheme_strap_1, ref_enable_strap, bandpass_filter_enable};
      s2b_reg <= s1b_reg;
    end
  end
  assign {cs_n_s, sclk_s, sdi_s, rstpin_s, xen_s, cfg0_s} = s2_reg;
  assign {cfg1_s, refen_s, bpf_s} = s2b_reg;
  assign core_rst = rst || !rstpin_s; // R06

  always_ff @(posedge clk) begin
    if (rst) begin
      // Idle level of the serial clock, so no false rising edge follows reset
      sclk_prev_reg <= 1'b1;
    end else begin
      sclk_prev_reg <= sclk_s;
    end
  end

  logic sclk_fall, sclk_rise;
  assign sclk_fall = sclk_prev_reg && !sclk_s;
  assign sclk_rise = !sclk_prev_reg && sclk_s;

  // Receive shift register and frame count
  localparam int CW = $clog2(WIDTH + 1);
  logic [WIDTH-1:0] shift_reg, shift_next;
  logic [CW-1:0] bit_cnt_reg;
  logic frame_done;
  assign shift_next = {shift_reg[WIDTH-2:0], sdi_s};
  assign frame_done = !cs_n_s && sclk_fall && (bit_cnt_reg == CW'(WIDTH - 1));

  always_ff @(posedge clk) begin
    if (core_rst || cs_n_s) begin
      bit_cnt_reg <= '0; // R02
    end else if (sclk_fall) begin
      shift_reg <= shift_next; // R01 R03
      bit_cnt_reg <= frame_done ? '0 : bit_cnt_reg + 1'b1;
    end
  end

  logic buf_in_ready, buf_out_valid;
  logic [WIDTH-1:0] buf_out_data;
  frame_buffer #(.WIDTH(WIDTH), .DEPTH(BUF_DEPTH)) u_rx_buf (
    .clk(clk),
    .rst(core_rst),
    .in_data(shift_next),
    .in_valid(frame_done),
    .in_ready(buf_in_ready),
    .out_data(buf_out_data),
    .out_valid(buf_out_valid),
    .out_ready(rx_ready && !rx_valid)
  );

  // Output stage registered so the top outputs come straight from flops
  always_ff @(posedge clk) begin
    if (core_rst) begin
      rx_valid <= 1'b0;
      rx_word <= '0;
      frame_overrun <= 1'b0;
    end else begin
      if (rx_valid && rx_ready) begin
        rx_valid <= 1'b0;
      end else if (!rx_valid && buf_out_valid && rx_ready) begin
        rx_valid <= 1'b1;
        rx_word <= buf_out_data;
      end
      // Only reached when the consumer stalls longer than two frames
      if (frame_done && !buf_in_ready) begin
        frame_overrun <= 1'b1;
      end
    end
  end

  // Transmit side: shifts out on rising edges, MSB first
  logic [WIDTH-1:0] tx_shift_reg;
  always_ff @(posedge clk) begin
    if (core_rst) begin
      tx_shift_reg <= '0;
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
    end else begin
      sdo_oe <= !cs_n_s; // R02
      if (cs_n_s) begin
        if (tx_load) begin
          tx_shift_reg <= tx_word;
        end
        sdo <= tx_load ? tx_word[WIDTH-1] : tx_shift_reg[WIDTH-1];
      end else if (sclk_rise && bit_cnt_reg != '0) begin
        sdo <= tx_shift_reg[WIDTH-2]; // R14 R04
        tx_shift_reg <= {tx_shift_reg[WIDTH-2:0], 1'b0};
      end
    end
  end

  // Interrupt generation
  logic any_event, evt_prev_reg;
  logic [$clog2(IRQ_PULSE_CYCLES+1)-1:0] pulse_cnt_reg;
  assign any_event = |(modem_events & irq_mask); // R08

  always_ff @(posedge clk) begin
    if (core_rst) begin
      evt_prev_reg <= 1'b0;
      pulse_cnt_reg <= '0;
      irq <= 1'b0;
    end else begin
      evt_prev_reg <= any_event;
      if (any_event && !evt_prev_reg) begin
        pulse_cnt_reg <= ($bits(pulse_cnt_reg))'(IRQ_PULSE_CYCLES);
      end else if (pulse_cnt_reg != '0) begin
        pulse_cnt_reg <= pulse_cnt_reg - 1'b1;
      end
      if (irq_mode == IRQ_MODE_PULSE) begin
        irq <= (pulse_cnt_reg != '0) ~^ irq_active_high; // R07
      end else begin
        irq <= any_event ~^ irq_active_high; // R07
      end
    end
  end

  // Straps and clock output
  logic [$clog2(DIV)-1:0] div_cnt_reg;
  logic src_ok;
  assign src_ok = clock_scheme != SCHEME_EXT_CMOS;
  always_ff @(posedge clk) begin
    if (core_rst) begin
      xtal_osc_on <= 1'b0;
      clock_scheme <= SCHEME_INT_OSC;
      internal_ref_on <= 1'b0;
      internal_filter_on <= 1'b0;
      power_down <= 1'b1;
      div_cnt_reg <= '0;
      clock_out_pin <= 1'b0;
    end else begin
      power_down <= 1'b0;
      xtal_osc_on <= !xen_s; // R09
      clock_scheme <= {cfg1_s, cfg0_s}; // R11
      internal_ref_on <= refen_s; // R12
      internal_filter_on <= bpf_s; // R13
      div_cnt_reg <= div_cnt_reg + 1'b1;
      clock_out_pin <= clock_out_enable && src_ok && div_cnt_reg[$bits(div_cnt_reg)-1]; // R10
    end
  end
  // Power-down is shown while the pin holds the core in reset
  // R05 relied on: 20 MHz sampling resolves sclk only up to a few MHz in this model
endmodule

/* bench/spi_asserts.sv */
`timescale 1ns/100ps
module spi_asserts
  import modem_spi_pkg::*;
#(
  parameter int WIDTH = FRAME_BITS,
  parameter int EVENTS = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic reset_pin_n,
  input wire logic cs_n,
  input wire logic sdo_oe,
  input wire logic [WIDTH-1:0] rx_word,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic [EVENTS-1:0] modem_events,
  input wire logic [EVENTS-1:0] irq_mask,
  input wire logic [1:0] irq_mode,
  input wire logic irq_active_high,
  input wire logic irq,
  input wire logic crystal_osc_enable_n,
  input wire logic xtal_osc_on,
  input wire logic ref_enable_strap,
  input wire logic internal_ref_on,
  input wire logic power_down
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst || !reset_pin_n);
  // Repetitions allow for the two-flop synchronisers on the pins
  AST_OE_IDLE: assert property (cs_n [*5] |-> !sdo_oe)
    else $error("sdo driven while deselected");
  AST_OE_SEL: assert property ((!cs_n && !power_down) [*5] |-> sdo_oe)
    else $error("sdo released while selected");
  AST_HOLD: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_word))
    else $error("rx word lost before taken");
  AST_MASK: assert property ((irq_mode == IRQ_MODE_LEVEL && (modem_events & irq_mask) == '0
    && $stable(irq_active_high)) [*6] |-> irq != irq_active_high)
    else $error("irq from masked event");
  AST_PULSE: assert property ($rose(irq) && irq_mode == IRQ_MODE_PULSE && irq_active_high
    |-> irq [*4] ##1 !irq)
    else $error("irq pulse width wrong");
  AST_PD: assert property (disable iff (1'b0) !reset_pin_n [*5] |-> power_down)
    else $error("no power down while reset pin low");
  AST_XTAL: assert property ((!power_down && $stable(crystal_osc_enable_n)) [*6]
    |-> xtal_osc_on != crystal_osc_enable_n)
    else $error("oscillator state wrong");
  AST_REF: assert property ((!power_down && $stable(ref_enable_strap)) [*6]
    |-> internal_ref_on == ref_enable_strap)
    else $error("reference state wrong");
endmodule

/* bench/spi_host.sv */
`timescale 1ns/100ps
module spi_host (
  input wire logic clk,
  input wire logic sdo_line,
  output logic cs_n,
  output logic sclk,
  output logic sdi
);
  initial begin
    cs_n = 1;
    sclk = 1;
    sdi = 0;
  end
  // Four clocks in each phase: a 400 ns period, far below the rate ceiling
  task automatic xfer(input logic [23:0] d, input int n, output logic [23:0] q);
    q = 0;
    // Deselect gap long enough to pass the pin synchronisers
    repeat (4) @(negedge clk);
    cs_n = 0;
    repeat (4) @(negedge clk);
    for (int i = 23; i > 23 - n; i--) begin
      sdi = d[i];
      repeat (4) @(negedge clk);
      sclk = 0;
      q = {q[22:0], sdo_line};
      repeat (4) @(negedge clk);
      sclk = 1;
    end
    repeat (4) @(negedge clk);
    cs_n = 1;
    sdi = ~sdi;
  endtask
endmodule

/* bench/modem_spi_pin_interface_bench.sv */
`timescale 1ns/100ps
module modem_spi_pin_interface_bench;
  import modem_spi_pkg::*;
  logic clk = 0, rst = 1, reset_pin_n = 1, cs_n, sclk, sdi, sdo, sdo_oe, rx_valid, rx_ready = 0, tx_load = 0;
  logic [23:0] rx_word, tx_word = 0, q;
  logic [7:0] modem_events = 0, irq_mask = 0;
  logic [1:0] irq_mode = 0, clock_scheme;
  logic irq_active_high = 1, irq, crystal_osc_enable_n = 1, clock_scheme_strap_0 = 0, clock_scheme_strap_1 = 0;
  logic ref_enable_strap = 0, bandpass_filter_enable = 0, clock_out_enable = 1, clock_out_pin, xtal_osc_on;
  logic internal_ref_on, internal_filter_on, power_down, frame_overrun, last = 0, sdo_line;
  int fail_count = 0, checks_done = 0, n;
  modem_spi_pin_interface uut (
    .clk(clk),
    .rst(rst),
    .reset_pin_n(reset_pin_n),
    .cs_n(cs_n),
    .sclk(sclk),
    .sdi(sdi),
    .sdo(sdo),
    .sdo_oe(sdo_oe),
    .rx_word(rx_word),
    .rx_valid(rx_valid),
    .rx_ready(rx_ready),
    .tx_word(tx_word),
    .tx_load(tx_load),
    .modem_events(modem_events),
    .irq_mask(irq_mask),
    .irq_mode(irq_mode),
    .irq_active_high(irq_active_high),
    .irq(irq),
    .crystal_osc_enable_n(crystal_osc_enable_n),
    .clock_scheme_strap_0(clock_scheme_strap_0),
    .clock_scheme_strap_1(clock_scheme_strap_1),
    .ref_enable_strap(ref_enable_strap),
    .bandpass_filter_enable(bandpass_filter_enable),
    .clock_out_enable(clock_out_enable),
    .clock_out_pin(clock_out_pin),
    .xtal_osc_on(xtal_osc_on),
    .clock_scheme(clock_scheme),
    .internal_ref_on(internal_ref_on),
    .internal_filter_on(internal_filter_on),
    .power_down(power_down),
    .frame_overrun(frame_overrun)
  );
  spi_host host (.clk, .sdo_line, .cs_n, .sclk, .sdi);
  // Released line shows the inverse of its last driven value
  always @(posedge clk) begin
    if (sdo_oe) begin
      last <= sdo;
    end
  end
  assign sdo_line = sdo_oe ? sdo : ~last;
  initial forever #25 clk = ~clk;
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // The design only raises rx_valid while the consumer is ready
  task automatic pop(input logic [23:0] exp);
    n = 0;
    rx_ready = 1;
    while (rx_valid !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    // One stalled cycle: the word must stand until it is accepted
    rx_ready = 0;
    @(negedge clk);
    chk(rx_word, exp);
    rx_ready = 1;
    @(negedge clk);
    rx_ready = 0;
  endtask
  task automatic end_sim;
    $display("fail_count=%0d checks_done=%0d", fail_count, checks_done);
    if (fail_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #1_000_000;
    fail_count++;
    end_sim;
  end
  initial begin
    repeat (10) @(negedge clk);
    rst = 0;
    repeat (6) @(negedge clk);
    chk(24'(power_down), 24'h0);
    for (int i = 0; i < 4; i++) begin
      {clock_scheme_strap_1, clock_scheme_strap_0} = 2'(i);
      crystal_osc_enable_n = i[0];
      ref_enable_strap = i[1];
      bandpass_filter_enable = ~i[0];
      repeat (6) @(negedge clk);
      chk(24'(clock_scheme), 24'(i));
      chk(24'({xtal_osc_on, internal_ref_on, internal_filter_on}), 24'({~i[0], i[1], ~i[0]}));
      n = 0;
      repeat (2 * CLKOUT_DIV) begin
        @(negedge clk);
        n += int'(clock_out_pin === 1'b1);
      end
      chk(24'(n), (2'(i) == SCHEME_EXT_CMOS) ? 24'h0 : 24'(CLKOUT_DIV));
    end
    clock_out_enable = 0;
    repeat (2) @(negedge clk);
    n = 0;
    repeat (2 * CLKOUT_DIV) begin
      @(negedge clk);
      n += int'(clock_out_pin === 1'b1);
    end
    chk(24'(n), 24'h0);
    tx_word = 24'hA5C3E1;
    tx_load = 1;
    @(negedge clk);
    tx_load = 0;
    host.xfer(24'h3C5A96, 24, q);
    chk(q, 24'hA5C3E1);
    repeat (5) @(negedge clk);
    chk(24'(sdo_oe), 24'h0);
    // Aborted frame must leave no word behind
    host.xfer(24'hFFFFFF, 10, q);
    for (int k = 0; k < 2; k++) begin
      host.xfer(24'h123450 + 24'(k), 24, q);
    end
    repeat (5) @(negedge clk);
    chk(24'(frame_overrun), 24'h1);
    pop(24'h3C5A96);
    pop(24'h123450);
    // Consumer ready: a dropped third frame must not surface
    rx_ready = 1;
    n = 0;
    repeat (4) begin
      @(negedge clk);
      n += int'(rx_valid === 1'b1);
    end
    rx_ready = 0;
    chk(24'(n), 24'h0);
    modem_events = 8'h04;
    repeat (6) @(negedge clk);
    chk(24'(irq), 24'h0);
    irq_mask = 8'h04;
    repeat (6) @(negedge clk);
    chk(24'(irq), 24'h1);
    irq_active_high = 0;
    repeat (6) @(negedge clk);
    chk(24'(irq), 24'h0);
    modem_events = 0;
    irq_active_high = 1;
    irq_mode = IRQ_MODE_PULSE;
    repeat (6) @(negedge clk);
    modem_events = 8'h04;
    n = 0;
    repeat (12) begin
      @(negedge clk);
      n += int'(irq === 1'b1);
    end
    chk(24'(n), 24'(IRQ_PULSE_CYCLES));
    reset_pin_n = 0;
    repeat (5) @(negedge clk);
    chk(24'({power_down, frame_overrun, rx_valid}), 24'h4);
    reset_pin_n = 1;
    end_sim;
  end
endmodule
bind modem_spi_pin_interface spi_asserts #(.WIDTH(WIDTH), .EVENTS(EVENTS)) chk_i (
  .clk(clk),
  .rst(rst),
  .reset_pin_n(reset_pin_n),
  .cs_n(cs_n),
  .sdo_oe(sdo_oe),
  .rx_word(rx_word),
  .rx_valid(rx_valid),
  .rx_ready(rx_ready),
  .modem_events(modem_events),
  .irq_mask(irq_mask),
  .irq_mode(irq_mode),
  .irq_active_high(irq_active_high),
  .irq(irq),
  .crystal_osc_enable_n(crystal_osc_enable_n),
  .xtal_osc_on(xtal_osc_on),
  .ref_enable_strap(ref_enable_strap),
  .internal_ref_on(internal_ref_on),
  .power_down(power_down)
);
